// *** bench/dfr_prot_model.sv ***
// protection modules: pickups, trips, reclose, triggers, samples
// driven off the bench clock, changed just after rising edges
`timescale 1ns/100ps
module dfr_prot_model (
  input wire logic clock,
  output logic [7:0] pickup,
  output logic [7:0] trip,
  output logic ar_active,
  output logic [7:0] trig_src,
  output logic [15:0] meas_in,
  output logic [15:0] samp_in
);
  initial begin
    pickup = 8'h00;
    trip = 8'h00;
    ar_active = 1'b0;
    trig_src = 8'h00;
    meas_in = 16'h0000;
    samp_in = 16'h0000;
  end
  // ramp so consecutive ticks differ by the tick divider
  always @(posedge clock) samp_in <= samp_in + 16'h0001;
  task automatic trig(input logic [7:0] v);
    @(posedge clock);
    trig_src <= v;
  endtask
  task automatic fault(input logic [7:0] pk, input logic [7:0] tr,
                       input logic ar, input logic [15:0] mv);
    @(posedge clock);
    ar_active <= ar;
    meas_in <= mv;
    @(posedge clock);
    pickup <= pk;
    repeat (40) @(posedge clock);
    trip <= tr;
    repeat (40) @(posedge clock);
    pickup <= 8'h00;
    trip <= 8'h00;
    ar_active <= 1'b0;
  endtask
endmodule

// *** bench/dfr_recorder_asserts.sv ***
// port checker of the recorder pair
// bound to dfr_recorder; one clock, srst synchronous
`timescale 1ns/100ps
module dfr_recorder_asserts #(
  parameter int TICK_DIV = dfr_pkg::TICK_DIV
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [7:0] pickup,
  input wire logic [7:0] trip,
  input wire logic dr_valid,
  input wire logic dr_first,
  input wire logic dr_last,
  input wire dfr_pkg::dfr_fnum_s dr_hdr,
  input wire logic fr_new,
  input wire dfr_pkg::dfr_frec_s nv_rec
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);
  logic gp;
  logic gp_d;
  logic in_rec;
  logic seen;
  logic [31:0] gap;
  assign gp = |pickup;
  // record span, trip seen in this fault, cycles since last sample
  always_ff @(posedge clock) begin
    if (srst) begin
      gp_d <= 1'b0;
      in_rec <= 1'b0;
      seen <= 1'b0;
      gap <= 32'h0000_0000;
    end else begin
      gp_d <= gp;
      in_rec <= !dr_last && (dr_first || in_rec);
      seen <= (gp && !gp_d) ? |trip : (seen || (gp && |trip));
      gap <= dr_valid ? 32'h0000_0000 : gap + 32'h0000_0001;
    end
  end
  chk_fall_pulse: assert property ($fell(gp) |=> fr_new)
    else $error("no pulse after pickup fall");
  chk_pulse_cause: assert property (fr_new |-> !$past(gp) && $past(gp, 2))
    else $error("pulse without pickup fall");
  chk_sample_gap: assert property (dr_valid && in_rec |-> gap == TICK_DIV - 1)
    else $error("sample spacing wrong");
  chk_marker_valid: assert property (dr_first || dr_last |-> dr_valid)
    else $error("marker without sample");
  chk_no_overlap: assert property (dr_first |-> !in_rec)
    else $error("record started inside record");
  chk_hdr_stable: assert property (in_rec |-> $stable(dr_hdr))
    else $error("header moved in record");
  chk_trip_flag: assert property (fr_new && seen |=> nv_rec.tripped)
    else $error("trip flag missing");
  chk_ttt_absent: assert property (!nv_rec.ttt_ok |-> nv_rec.ttt == 16'h0000)
    else $error("absent time not zero");
  chk_nv_update: assert property ($changed(nv_rec) |-> fr_new || $past(fr_new))
    else $error("stored record moved alone");
  cover property (fr_new && seen);
  cover property (dr_last);
  cover property (nv_rec.tripped && !nv_rec.ttt_ok);
endmodule
bind dfr_recorder dfr_recorder_asserts #(.TICK_DIV(TICK_DIV)) u_chk (
  .clock(clock), .srst(srst), .pickup(pickup), .trip(trip),
  .dr_valid(dr_valid), .dr_first(dr_first), .dr_last(dr_last),
  .dr_hdr(dr_hdr), .fr_new(fr_new), .nv_rec(nv_rec));

// *** bench/dfr_recorder_bench.sv ***
// self-checking bench of the recorder pair
// assumes dfr_pkg, dfr_recorder and dfr_prot_model compiled first
`timescale 1ns/100ps
module dfr_recorder_bench;
  localparam int TD = 8;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic [3:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic rd_d = 1'b0;
  logic fr_pend = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0] trig_src, pickup, trip;
  logic ar_active, dr_valid, dr_first, dr_last, fr_new;
  logic [15:0] meas_in, samp_in, dr_data, prev;
  logic [15:0] seed = 16'hd21e;
  logic [49:0] last;
  dfr_pkg::dfr_fnum_s dr_hdr;
  dfr_pkg::dfr_frec_s nv_rec;
  logic [31:0] q_rd[$];
  logic [49:0] q_fr[$];
  int q_len[$];
  int n_fail = 0;
  int cmp_count = 0;
  int n_rec = 0;
  int len = 0;
  int cyc = 0;
  logic [7:0] pk[4] = '{8'h02, 8'h04, 8'h08, 8'h01};
  logic [7:0] tp[4] = '{8'h02, 8'h20, 8'h00, 8'h00};
  initial forever #10 clock = ~clock;
  dfr_recorder #(.TICK_DIV(TD)) u_dut (
    .clock(clock), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trig_src(trig_src), .pickup(pickup),
    .trip(trip), .ar_active(ar_active), .meas_in(meas_in),
    .samp_in(samp_in), .dr_valid(dr_valid), .dr_data(dr_data),
    .dr_first(dr_first), .dr_last(dr_last), .dr_hdr(dr_hdr),
    .fr_new(fr_new), .nv_rec(nv_rec));
  dfr_prot_model u_prot (
    .clock(clock), .pickup(pickup), .trip(trip), .ar_active(ar_active),
    .trig_src(trig_src), .meas_in(meas_in), .samp_in(samp_in));
  // ==========================================================
  // helpers
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input logic [49:0] got, input logic [49:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    if (!w) q_rd.push_back(d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= w;
    reg_rd <= !w;
    @(posedge clock);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================================
  // monitor: takes the oldest note as each result appears
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
    if (rd_d) chk(50'(reg_rdata), 50'(q_rd.pop_front()));
    rd_d <= reg_rd;
    if (fr_pend) chk({nv_rec.num, nv_rec.tripped, nv_rec.ttt_ok,
                      nv_rec.meas}, q_fr.pop_front());
    fr_pend <= fr_new;
    if (dr_valid) begin
      if (!dr_first) chk(50'(dr_data - prev), 50'(16'(TD)));
      prev <= dr_data;
      len = dr_first ? 1 : len + 1;
      n_rec += int'(dr_first);
      if (dr_last) chk(50'(len), 50'(q_len.pop_front()));
      if (dr_first) chk(50'(dr_hdr), 50'(32'h0004_0003));
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    {reg_addr, reg_wdata, reg_wr, reg_rd} <= '0;
    repeat (2) @(posedge clock);
    srst <= 1'b0;
    bus(1'b0, dfr_pkg::REG_CFG, 32'h050a_0c80);
    bus(1'b0, dfr_pkg::REG_TSEL, 32'h0000_0000);
    bus(1'b0, 4'hf, 32'h0000_0000);
    bus(1'b1, dfr_pkg::REG_CFG, 32'h0505_0014);
    bus(1'b1, dfr_pkg::REG_TSEL, 32'h0000_0008);
    $display("registers done");
    for (int i = 0; i < 4; i++) begin
      if (i == 3) bus(1'b1, dfr_pkg::REG_CFG, 32'h4505_0014);
      seed = lfsr(seed);
      if (i != 2) last = {16'(i + 1), 16'(i ? i : 1), i < 2, i == 0, seed};
      q_fr.push_back(last);
      u_prot.fault(pk[i], tp[i], i == 1, seed);
      repeat (10) @(posedge clock);
      bus(1'b0, dfr_pkg::REG_FCNT,
          {16'(i + 1), 16'(i ? i : 1)});
    end
    $display("faults done");
    u_prot.trig(8'h01);
    repeat (200) @(posedge clock);
    chk(50'(n_rec), 50'(0));
    q_len.push_back(20);
    u_prot.trig(8'h09);
    repeat (400) @(posedge clock);
    chk(50'(n_rec), 50'(1));
    u_prot.trig(8'h00);
    repeat (50) @(posedge clock);
    q_len.push_back(20);
    u_prot.trig(8'h08);
    repeat (300) @(posedge clock);
    u_prot.trig(8'h00);
    q_len.push_back(6);
    bus(1'b1, dfr_pkg::REG_CMD, 32'h0000_0001);
    repeat (150) @(posedge clock);
    chk(50'(n_rec), 50'(3));
    $display("records done");
    print_verdict();
  end
endmodule

// *** common/dfr_pkg.sv ***
// constants, register map and record layouts of the recorder pair
// assumes a 50 MHz system clock and one grid-frequency sample timebase
package dfr_pkg;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 50_000_000;
  localparam int GRID_HZ = 50;
  localparam int SAMP_PER_CYC = 32;
  localparam int SAMP_HZ = GRID_HZ * SAMP_PER_CYC;
  localparam int TICK_DIV = CLK_HZ / SAMP_HZ;
  localparam int LIMIT_MAX_S = 15;
  localparam int CAP_S = 120;
  localparam logic [14:0] LIMIT_MAX = 15'(LIMIT_MAX_S * SAMP_HZ);
  localparam logic [17:0] CAPACITY = 18'(CAP_S * SAMP_HZ);
  localparam logic [6:0] PCT_FULL = 7'h64;
  // ==========================================================
  // sizes
  localparam int N_TRIG = 8;
  localparam int N_MOD = 8;
  localparam int FR_DEPTH = 20;
  localparam int DR_SLOTS = 16;
  localparam int BUF_AW = 15;
  // ==========================================================
  // register offsets
  localparam logic [3:0] REG_CFG = 4'h0;
  localparam logic [3:0] REG_TSEL = 4'h1;
  localparam logic [3:0] REG_FDLY = 4'h2;
  localparam logic [3:0] REG_CMD = 4'h3;
  localparam logic [3:0] REG_STAT = 4'h4;
  localparam logic [3:0] REG_USED = 4'h5;
  localparam logic [3:0] REG_FCNT = 4'h6;
  localparam logic [3:0] REG_FSEL = 4'h7;
  localparam logic [3:0] REG_FR_A = 4'h8;
  localparam logic [3:0] REG_FR_B = 4'h9;
  localparam logic [3:0] REG_FR_C = 4'ha;
  // ==========================================================
  // field positions
  localparam int CFG_LIM_LSB = 0;
  localparam int CFG_PRE_LSB = 15;
  localparam int CFG_POST_LSB = 22;
  localparam int CFG_OVW_BIT = 29;
  localparam int CFG_MODE_BIT = 30;
  localparam int CMD_MAN_BIT = 0;
  localparam int CMD_DEL1_BIT = 1;
  localparam int CMD_DELA_BIT = 2;
  localparam int CMD_IDX_LSB = 8;
  localparam int CMD_KEY_LSB = 16;
  // ==========================================================
  // reset values
  localparam logic [14:0] LIMIT_RST = 15'h0c80;
  localparam logic [6:0] PRE_RST = 7'h14;
  localparam logic [6:0] POST_RST = 7'h14;
  localparam logic [7:0] TSEL_RST = 8'h00;
  localparam logic [15:0] FDLY_RST = 16'h0000;
  // ==========================================================
  // types
  typedef enum logic [1:0] {
    DR_IDLE = 2'b00,
    DR_REC = 2'b01,
    DR_HOLD = 2'b10
  } dfr_dr_e;
  typedef struct packed {
    logic [15:0] fault_no;
    logic [15:0] grid_no;
  } dfr_fnum_s;
  typedef struct packed {
    dfr_fnum_s num;
    logic tripped;
    logic ttt_ok;
    logic [15:0] ttt;
    logic [15:0] dur;
    logic [15:0] meas;
  } dfr_frec_s;
endpackage

// *** hw/dfr_recorder.sv ***
// disturbance and fault recorders of a protection relay
// inputs come from protection logic on the same clock; samples and
// record stream are one 16-bit channel on the internal sample tick
`timescale 1ns/100ps
// How it works
// (R1) sample tick runs at 32 per grid cycle
// (R2) selected trigger sources are ORed; rising OR starts a record
// (R3) after a record, wait until all starting sources are inactive
// (R4) record length limit clamps to 15 s
// (R5) lead and tail set as percent of the length limit
// (R6) lead section always equals the lead duration
// (R7) event lasts trigger time, capped at limit minus lead
// (R8) tail is setting, capped by remaining limit; may be zero
// (R9) recording always stops when the length limit is reached
// (R10) storage accounting totals 120 s of samples
// (R11) full: overwrite oldest if enabled, else stop until cleared
// (R12) software may start a record by manual command
// (R13) deleting needs the key; one selected record or all
// (R14) fault recorder starts on rising OR of all pickups
// (R15) measurements latched at trip or after set delay
// (R16) untripped pickup recorded only in alarms-and-trips mode
// (R17) time-to-trip first pickup to trip; absent if modules differ
// (R18) fault duration spans general pickup; general trip ORs trips
// (R19) new-fault pulse on every falling pickup, whether or not a record is stored
// (R20) 20 fault records, oldest overwritten first
// (R21) newest fault record held on a port for retained storage
// (R22) each fault record flags whether it tripped
// (R23) both recorders carry fault and grid fault numbers
// (R24) fault number increments on each general pickup
// (R25) grid fault number skips pickups during auto-reclose
// (R26) all durations counted in sample periods
// (R27) lead comes from a circular buffer of recent samples
module dfr_recorder #(
  parameter int TICK_DIV = dfr_pkg::TICK_DIV,
  parameter logic [15:0] DEL_KEY = 16'h5a5a // arbitrary
) (
  input wire logic clock,
  input wire logic srst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [7:0] trig_src,
  input wire logic [7:0] pickup,
  input wire logic [7:0] trip,
  input wire logic ar_active,
  input wire logic [15:0] meas_in,
  input wire logic [15:0] samp_in,
  output logic dr_valid,
  output logic [15:0] dr_data,
  output logic dr_first,
  output logic dr_last,
  output dfr_pkg::dfr_fnum_s dr_hdr,
  output logic fr_new,
  output dfr_pkg::dfr_frec_s nv_rec
);
  // ==========================================================
  // helpers
  function automatic logic [14:0] pct_of(input logic [14:0] l,
                                         input logic [6:0] p);
    logic [21:0] m;
    m = 22'(l) * 22'(p);
    return 15'(m / 22'(dfr_pkg::PCT_FULL));
  endfunction

  function automatic logic [2:0] first_idx(input logic [7:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = dfr_pkg::N_MOD - 1; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction

  function automatic logic [4:0] fr_wrap(input logic [5:0] v);
    return (v >= 6'(dfr_pkg::FR_DEPTH)) ?
           5'(v - 6'(dfr_pkg::FR_DEPTH)) : 5'(v);
  endfunction

  // ==========================================================
  // sample tick divider
  logic [15:0] div_reg;
  wire tick = (div_reg == 16'(TICK_DIV - 1)); // (R1)
  always_ff @(posedge clock) begin
    if (srst || tick) begin
      div_reg <= 16'h0000;
    end else begin
      div_reg <= div_reg + 16'h0001;
    end
  end

  // ==========================================================
  // configuration registers
  logic [14:0] record_length_limit_reg;
  logic [6:0] lead_pct_reg;
  logic [6:0] tail_pct_reg;
  logic ovw_reg;
  logic mode_all_reg;
  logic [7:0] tsel_reg;
  logic [15:0] fdly_reg;
  logic [4:0] fsel_reg;

  wire wr_cfg = reg_wr && (reg_addr == dfr_pkg::REG_CFG);
  wire wr_cmd = reg_wr && (reg_addr == dfr_pkg::REG_CMD);
  wire [14:0] w_lim = reg_wdata[dfr_pkg::CFG_LIM_LSB +: 15];
  wire [6:0] w_pre = reg_wdata[dfr_pkg::CFG_PRE_LSB +: 7];
  wire [6:0] w_post = reg_wdata[dfr_pkg::CFG_POST_LSB +: 7];
  wire [14:0] lim_clamp = (w_lim > dfr_pkg::LIMIT_MAX) ?
      dfr_pkg::LIMIT_MAX : ((w_lim == 15'h0000) ? 15'h0001 : w_lim);
  wire [6:0] pre_clamp = (w_pre > dfr_pkg::PCT_FULL) ?
      dfr_pkg::PCT_FULL : w_pre;
  wire [6:0] post_clamp = (w_post > dfr_pkg::PCT_FULL) ?
      dfr_pkg::PCT_FULL : w_post;
  wire key_ok = reg_wdata[dfr_pkg::CMD_KEY_LSB +: 16] == DEL_KEY;
  wire cmd_man = wr_cmd && reg_wdata[dfr_pkg::CMD_MAN_BIT]; // (R12)
  wire cmd_dela = wr_cmd && key_ok &&
      reg_wdata[dfr_pkg::CMD_DELA_BIT]; // (R13)
  wire cmd_del1 = wr_cmd && key_ok && !cmd_dela &&
      reg_wdata[dfr_pkg::CMD_DEL1_BIT]; // (R13)
  wire [3:0] del_idx = reg_wdata[dfr_pkg::CMD_IDX_LSB +: 4];

  always_ff @(posedge clock) begin
    if (srst) begin
      record_length_limit_reg <= dfr_pkg::LIMIT_RST;
      lead_pct_reg <= dfr_pkg::PRE_RST;
      tail_pct_reg <= dfr_pkg::POST_RST;
      ovw_reg <= 1'b0;
      mode_all_reg <= 1'b0;
      tsel_reg <= dfr_pkg::TSEL_RST;
      fdly_reg <= dfr_pkg::FDLY_RST;
      fsel_reg <= 5'h00;
    end else if (reg_wr) begin
      if (wr_cfg) begin
        record_length_limit_reg <= lim_clamp; // (R4)
        lead_pct_reg <= pre_clamp; // (R5)
        tail_pct_reg <= post_clamp; // (R5)
        ovw_reg <= reg_wdata[dfr_pkg::CFG_OVW_BIT];
        mode_all_reg <= reg_wdata[dfr_pkg::CFG_MODE_BIT];
      end
      if (reg_addr == dfr_pkg::REG_TSEL) begin
        tsel_reg <= reg_wdata[7:0];
      end
      if (reg_addr == dfr_pkg::REG_FDLY) begin
        fdly_reg <= reg_wdata[15:0];
      end
      if (reg_addr == dfr_pkg::REG_FSEL) begin
        fsel_reg <= reg_wdata[4:0];
      end
    end
  end

  // ==========================================================
  // circular lead buffer, written every tick
  logic [15:0] lead_mem [0:(1 << dfr_pkg::BUF_AW) - 1];
  logic [14:0] wp_reg;
  logic [14:0] lead_duration_reg;
  logic [14:0] tail_duration_setting_reg;
  logic [14:0] lim_r_reg;
  dfr_pkg::dfr_dr_e dr_state_reg;

  wire [14:0] rd_ptr = wp_reg - lead_duration_reg; // (R27)
  wire [15:0] lead_out = (lead_duration_reg == 15'h0000) ?
      samp_in : lead_mem[rd_ptr]; // (R6)

  always_ff @(posedge clock) begin
    if (tick) begin
      lead_mem[wp_reg] <= samp_in; // (R27)
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      wp_reg <= 15'h0000;
    end else if (tick) begin
      wp_reg <= wp_reg + 15'h0001;
    end
  end

  // settings frozen while a record runs
  always_ff @(posedge clock) begin
    if (srst) begin
      lead_duration_reg <= 15'h0000;
      tail_duration_setting_reg <= 15'h0000;
      lim_r_reg <= dfr_pkg::LIMIT_RST;
    end else if (dr_state_reg != dfr_pkg::DR_REC) begin
      lead_duration_reg <= pct_of(record_length_limit_reg,
                                  lead_pct_reg); // (R5)
      tail_duration_setting_reg <= pct_of(record_length_limit_reg,
                                          tail_pct_reg); // (R5)
      lim_r_reg <= record_length_limit_reg;
    end
  end

  // ==========================================================
  // storage accounting
  logic [15:0] slot_valid_reg;
  logic [14:0] slot_len [0:dfr_pkg::DR_SLOTS - 1];
  logic [3:0] slot_wp_reg;
  logic [3:0] slot_old_reg;
  logic [17:0] used_reg;
  logic start_pend_reg;
  logic full_reg;

  wire [18:0] need = 19'(used_reg) + 19'(lim_r_reg);
  wire fits = (need <= 19'(dfr_pkg::CAPACITY)) &&
      !slot_valid_reg[slot_wp_reg]; // (R10)
  wire evict = ovw_reg && start_pend_reg && !fits &&
      !cmd_dela && !cmd_del1; // (R11)
  wire evict_hit = evict && slot_valid_reg[slot_old_reg];
  wire del1_hit = cmd_del1 && slot_valid_reg[del_idx];

  // ==========================================================
  // disturbance record sequencing
  logic [7:0] cause_reg;
  logic or_prev_reg;
  logic [14:0] n_reg;
  logic [14:0] event_duration_reg;
  logic ev_done_reg;

  wire trig_or = |(trig_src & tsel_reg); // (R2)
  wire trig_rise = trig_or && !or_prev_reg; // (R2)
  wire [14:0] ev_cap = lim_r_reg - lead_duration_reg;
  wire [14:0] rest = ev_cap - event_duration_reg;
  wire [14:0] tail_duration_actual =
      (tail_duration_setting_reg < rest) ?
      tail_duration_setting_reg : rest; // (R8)
  wire [15:0] stop_n = 16'(lead_duration_reg) +
      16'(event_duration_reg) + 16'(tail_duration_actual);
  wire [15:0] n_inc = 16'(n_reg) + 16'h0001;
  wire rec_end = (ev_done_reg && (n_inc >= stop_n)) ||
      (n_inc >= 16'(lim_r_reg)); // (R9)
  wire rec_tick = tick && (dr_state_reg == dfr_pkg::DR_REC);
  wire store = rec_tick && rec_end;
  wire go = tick && (dr_state_reg == dfr_pkg::DR_IDLE) &&
      start_pend_reg && fits;

  always_ff @(posedge clock) begin
    if (srst) begin
      start_pend_reg <= 1'b0;
      full_reg <= 1'b0;
      or_prev_reg <= 1'b0;
    end else begin
      if (tick) begin
        or_prev_reg <= trig_or;
      end
      if (tick && start_pend_reg && !fits && !ovw_reg) begin
        full_reg <= 1'b1; // (R11)
      end else if (cmd_dela || cmd_del1) begin
        full_reg <= 1'b0; // (R11)
      end
      if (go || (tick && start_pend_reg && !fits && !ovw_reg)) begin
        start_pend_reg <= 1'b0;
      end else if (cmd_man ||
          (tick && trig_rise && !full_reg &&
           dr_state_reg == dfr_pkg::DR_IDLE)) begin
        start_pend_reg <= 1'b1; // (R12)
      end
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      dr_state_reg <= dfr_pkg::DR_IDLE;
      cause_reg <= 8'h00;
      n_reg <= 15'h0000;
      event_duration_reg <= 15'h0000;
      ev_done_reg <= 1'b0;
    end else begin
      case (dr_state_reg)
        dfr_pkg::DR_IDLE: begin
          if (go) begin
            dr_state_reg <= dfr_pkg::DR_REC;
            cause_reg <= trig_src & tsel_reg; // (R3)
            n_reg <= 15'h0000;
            event_duration_reg <= 15'h0000;
            ev_done_reg <= (ev_cap == 15'h0000);
          end
        end
        dfr_pkg::DR_REC: begin
          if (rec_tick) begin
            n_reg <= n_reg + 15'h0001; // (R26)
            if (!ev_done_reg) begin
              if (trig_or && event_duration_reg < ev_cap) begin
                event_duration_reg <= event_duration_reg +
                    15'h0001; // (R7)
              end
              if (!trig_or || event_duration_reg + 15'h0001 >= ev_cap)
              begin
                ev_done_reg <= 1'b1; // (R7)
              end
            end
            if (rec_end) begin
              dr_state_reg <= dfr_pkg::DR_HOLD;
            end
          end
        end
        dfr_pkg::DR_HOLD: begin
          if ((trig_src & cause_reg) == 8'h00) begin
            dr_state_reg <= dfr_pkg::DR_IDLE; // (R3)
          end
        end
        default: begin
          dr_state_reg <= dfr_pkg::DR_IDLE;
        end
      endcase
    end
  end

  // slot bookkeeping; one update source per cycle except store
  always_ff @(posedge clock) begin
    if (srst || cmd_dela) begin
      slot_valid_reg <= 16'h0000; // (R13)
      slot_wp_reg <= 4'h0;
      slot_old_reg <= 4'h0;
      used_reg <= 18'h0_0000;
    end else begin
      used_reg <= used_reg
          + (store ? 18'(n_inc) : 18'h0_0000)
          - (evict_hit ? 18'(slot_len[slot_old_reg]) : 18'h0_0000)
          - (del1_hit ? 18'(slot_len[del_idx]) : 18'h0_0000); // (R10)
      if (evict) begin
        slot_valid_reg[slot_old_reg] <= 1'b0; // (R11)
        slot_old_reg <= slot_old_reg + 4'h1;
      end
      if (del1_hit) begin
        slot_valid_reg[del_idx] <= 1'b0; // (R13)
      end
      if (store) begin
        slot_valid_reg[slot_wp_reg] <= 1'b1;
        slot_wp_reg <= slot_wp_reg + 4'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (store) begin
      slot_len[slot_wp_reg] <= n_inc[14:0];
    end
  end

  // record stream
  always_ff @(posedge clock) begin
    if (srst) begin
      dr_valid <= 1'b0;
      dr_data <= 16'h0000;
      dr_first <= 1'b0;
      dr_last <= 1'b0;
    end else begin
      dr_valid <= rec_tick;
      dr_first <= rec_tick && (n_reg == 15'h0000);
      dr_last <= store;
      if (rec_tick) begin
        dr_data <= lead_out; // (R6)
      end
    end
  end

  // ==========================================================
  // fault recorder
  logic gp_prev_reg;
  logic fr_act_reg;
  logic [2:0] first_pk_reg;
  logic [15:0] fault_no_reg;
  logic [15:0] grid_no_reg;
  logic tripped_reg;
  logic ttt_ok_reg;
  logic [15:0] ttt_reg;
  logic [15:0] dur_reg;
  logic meas_wait_reg;
  logic meas_done_reg;
  logic [15:0] dly_reg;
  logic [15:0] meas_reg;
  dfr_pkg::dfr_frec_s fr_mem [0:dfr_pkg::FR_DEPTH - 1];
  logic [4:0] fr_wp_reg;
  logic [4:0] fr_cnt_reg;

  wire gp = |pickup; // (R14)
  wire gt = |trip; // (R18)
  wire gp_rise = gp && !gp_prev_reg; // (R14)
  wire gp_fall = !gp && gp_prev_reg && fr_act_reg;
  wire first_trip = fr_act_reg && gt && !tripped_reg;
  wire meas_now = (first_trip && fdly_reg == 16'h0000) ||
      (meas_wait_reg && tick && dly_reg + 16'h0001 >= fdly_reg);
  wire fr_store = gp_fall && (tripped_reg || mode_all_reg); // (R16)
  wire [4:0] fr_wp_inc = fr_wrap(6'(fr_wp_reg) + 6'h01);

  dfr_pkg::dfr_frec_s fr_rec;
  assign fr_rec.num.fault_no = fault_no_reg;
  assign fr_rec.num.grid_no = grid_no_reg;
  assign fr_rec.tripped = tripped_reg; // (R22)
  assign fr_rec.ttt_ok = ttt_ok_reg; // (R17)
  assign fr_rec.ttt = ttt_ok_reg ? ttt_reg : 16'h0000; // (R17)
  assign fr_rec.dur = dur_reg; // (R18)
  assign fr_rec.meas = meas_done_reg ? meas_reg : meas_in;

  always_ff @(posedge clock) begin
    if (srst) begin
      gp_prev_reg <= 1'b0;
      fr_act_reg <= 1'b0;
      first_pk_reg <= 3'h0;
      fault_no_reg <= 16'h0000;
      grid_no_reg <= 16'h0000;
      tripped_reg <= 1'b0;
      ttt_ok_reg <= 1'b0;
      ttt_reg <= 16'h0000;
      dur_reg <= 16'h0000;
      meas_wait_reg <= 1'b0;
      meas_done_reg <= 1'b0;
      dly_reg <= 16'h0000;
      meas_reg <= 16'h0000;
    end else begin
      gp_prev_reg <= gp;
      if (gp_rise) begin
        fr_act_reg <= 1'b1;
        first_pk_reg <= first_idx(pickup);
        fault_no_reg <= fault_no_reg + 16'h0001; // (R24)
        if (!ar_active) begin
          grid_no_reg <= grid_no_reg + 16'h0001; // (R25)
        end
        tripped_reg <= 1'b0;
        ttt_ok_reg <= 1'b0;
        ttt_reg <= 16'h0000;
        dur_reg <= 16'h0000;
        meas_wait_reg <= 1'b0;
        meas_done_reg <= 1'b0;
      end else if (fr_act_reg) begin
        if (tick) begin
          dur_reg <= dur_reg + 16'h0001; // (R18)
          if (!tripped_reg) begin
            ttt_reg <= ttt_reg + 16'h0001; // (R26)
          end
        end
        if (first_trip) begin
          tripped_reg <= 1'b1;
          ttt_ok_reg <= first_idx(trip) == first_pk_reg; // (R17)
          meas_wait_reg <= fdly_reg != 16'h0000;
          dly_reg <= 16'h0000;
        end else if (meas_wait_reg && tick) begin
          dly_reg <= dly_reg + 16'h0001;
        end
        if (meas_now) begin
          meas_reg <= meas_in; // (R15)
          meas_done_reg <= 1'b1;
          meas_wait_reg <= 1'b0;
        end
        if (gp_fall) begin
          fr_act_reg <= 1'b0;
          meas_wait_reg <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clock) begin
    if (fr_store) begin
      fr_mem[fr_wp_reg] <= fr_rec; // (R20)
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      fr_wp_reg <= 5'h00;
      fr_cnt_reg <= 5'h00;
      fr_new <= 1'b0;
      nv_rec <= '0;
      dr_hdr <= '0;
    end else begin
      fr_new <= gp_fall; // (R19)
      if (fr_store) begin
        fr_wp_reg <= fr_wp_inc; // (R20)
        if (fr_cnt_reg != 5'(dfr_pkg::FR_DEPTH)) begin
          fr_cnt_reg <= fr_cnt_reg + 5'h01;
        end
        nv_rec <= fr_rec; // (R21)
      end
      if (go) begin
        dr_hdr <= fr_rec.num; // (R23)
      end
    end
  end

  // ==========================================================
  // register read, data in the cycle after the strobe
  wire [4:0] sel_idx = fr_wrap(6'(fr_wp_reg) +
      6'(dfr_pkg::FR_DEPTH - 1) - 6'(fsel_reg));
  wire sel_ok = fsel_reg < fr_cnt_reg;
  dfr_pkg::dfr_frec_s fr_sel;
  assign fr_sel = sel_ok ? fr_mem[sel_idx] : '0;
  wire [4:0] dr_count = 5'($countones(slot_valid_reg));

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (reg_addr)
      dfr_pkg::REG_CFG: rd_mux = {1'b0, mode_all_reg, ovw_reg,
          tail_pct_reg, lead_pct_reg, record_length_limit_reg};
      dfr_pkg::REG_TSEL: rd_mux = {24'h00_0000, tsel_reg};
      dfr_pkg::REG_FDLY: rd_mux = {16'h0000, fdly_reg};
      dfr_pkg::REG_STAT: rd_mux = {11'h000, fr_cnt_reg, 3'h0,
          dr_count, 5'h00, full_reg, dr_state_reg};
      dfr_pkg::REG_USED: rd_mux = {14'h0000, used_reg};
      dfr_pkg::REG_FCNT: rd_mux = {fault_no_reg, grid_no_reg};
      dfr_pkg::REG_FSEL: rd_mux = {27'h000_0000, fsel_reg};
      dfr_pkg::REG_FR_A: rd_mux = fr_sel.num;
      dfr_pkg::REG_FR_B: rd_mux = {sel_ok, 13'h0000,
          fr_sel.tripped, fr_sel.ttt_ok, fr_sel.ttt};
      dfr_pkg::REG_FR_C: rd_mux = {fr_sel.dur, fr_sel.meas};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
    end
  end
endmodule
